//--- fqdbi_pkg.sv
// Package for the quad-pumped data phase with per-group inversion.
// Assumes both ends and the interface import it.
package fqdbi_pkg;
  // ****************************************
  // Bus shape
  // ****************************************
  localparam int DATA_W = 64;
  localparam int GROUP_W = 16;
  localparam int GROUPS = DATA_W / GROUP_W;
  localparam int BEATS = 4;
  localparam int BEAT_W = 2;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int BEAT_NS = 40;
  localparam int BEAT_CYC = (BEAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CYC = BEAT_CYC / 2;
  localparam logic [3:0] HALF_CNT = 4'(HALF_CYC - 1);
  localparam logic [4:0] DBI_LIMIT = 5'(GROUP_W / 2);
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BEATS - 1);
endpackage

//--- fqdbi_if.sv
// Interface joining the driving end and the receiving end.
// Assumes the bench resolves nothing; every line has one driver here.
`timescale 1ns/10ps
interface fqdbi_if
  import fqdbi_pkg::*;
();
  logic [DATA_W-1:0] data_n;
  logic [GROUPS-1:0] data_strobe_pos_n;
  logic [GROUPS-1:0] data_strobe_neg_n;
  logic [GROUPS-1:0] group_invert_n;
  logic data_valid_n;
  logic data_bus_in_use_n;
  modport driver (output data_n, data_strobe_pos_n, data_strobe_neg_n, group_invert_n,
    data_valid_n, data_bus_in_use_n);
  modport receiver (input data_n, data_strobe_pos_n, data_strobe_neg_n, group_invert_n,
    data_valid_n, data_bus_in_use_n);
endinterface

//--- fqdbi_driver.sv
// Driving end: sends bursts of four 64-bit words with per-group inversion.
// Assumes user holds send_word stable while send_valid and not send_ready.
// Operation
// - Data path is 64 bits, shared
// - Valid low marks each data transfer
// - Four data values per bus period
// - Receiver latches on both strobe falls
// - Each 16-bit group has strobe pair
// - Each group has own inversion line
// - Active inversion means group inverted
// - Inversion line active exactly when inverted
// - Invert when over half bits change
// - Busy held while using data bus
`timescale 1ns/10ps
module fqdbi_driver
  import fqdbi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [DATA_W-1:0] send_word,
  input wire logic send_valid,
  output logic send_ready,
  fqdbi_if.driver bus
);
  typedef enum logic [1:0] {FQ_IDLE, FQ_HALF_A, FQ_HALF_B, FQ_DONE} fqdbi_state_type;

  // ****************************************
  // Inversion choice
  // ****************************************
  // Counts lines that would change between two wire levels
  function automatic logic [4:0] fqdbi_changes(input logic [GROUP_W-1:0] a,
    input logic [GROUP_W-1:0] b);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < GROUP_W; i++)
      n = n + 5'(a[i] ^ b[i]);
    return n;
  endfunction

  // Open states: the sequencer may take a fresh burst here
  function automatic logic fqdbi_is_open(input fqdbi_state_type s);
    logic is_open;
    is_open = (s == FQ_IDLE) || (s == FQ_DONE);
    return is_open;
  endfunction

  // Beat states: a transfer stands on the lines here
  function automatic logic fqdbi_is_beat(input fqdbi_state_type s);
    logic in_beat;
    in_beat = (s == FQ_HALF_A) || (s == FQ_HALF_B);
    return in_beat;
  endfunction

  fqdbi_state_type state;
  fqdbi_state_type next_state;
  logic [3:0] cnt;
  logic [BEAT_W-1:0] beat;
  logic strobe_phase;
  logic [DATA_W-1:0] wire_data;
  logic [GROUPS-1:0] inv_n;
  logic [GROUPS-1:0] spos_n;
  logic [GROUPS-1:0] sneg_n;
  logic valid_n;
  logic busy_n;
  logic ready;
  logic [DATA_W-1:0] plain_level;
  logic [DATA_W-1:0] next_wire;
  logic [GROUPS-1:0] next_inv_n;
  wire open_now = fqdbi_is_open(state);
  wire beat_next = fqdbi_is_beat(next_state);
  wire tick = (cnt == HALF_CNT);

  // Active-low encoding before any inversion
  assign plain_level = ~send_word;

  // Per group: compare against the level now on the lines
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++)
    begin : g_dbi
      wire [GROUP_W-1:0] cur = wire_data[g*GROUP_W +: GROUP_W];
      wire [GROUP_W-1:0] raw = plain_level[g*GROUP_W +: GROUP_W];
      wire flip = fqdbi_changes(cur, raw) > DBI_LIMIT;
      assign next_wire[g*GROUP_W +: GROUP_W] = flip ? ~raw : raw;
      assign next_inv_n[g] = ~flip;
    end
  endgenerate

  // ****************************************
  // Beat sequencer
  // ****************************************
  // Each beat spans two half periods; one strobe falls per beat
  always_comb
  begin
    next_state = state;
    case (state)
      FQ_IDLE: if (send_valid) next_state = FQ_HALF_A;
      FQ_HALF_A: if (tick) next_state = FQ_HALF_B;
      FQ_HALF_B:
        if (tick) next_state = (beat == LAST_BEAT) ? FQ_DONE : FQ_HALF_A;
      FQ_DONE: next_state = send_valid ? FQ_HALF_A : FQ_IDLE;
      default: next_state = FQ_IDLE;
    endcase
  end

  // Word is taken on the idle or done edge, or at the end of each beat but the last
  wire load = (open_now && send_valid) ||
    (state == FQ_HALF_B && tick && beat != LAST_BEAT);
  wire fall = (state == FQ_HALF_A && tick);

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= FQ_IDLE;
    else
      state <= next_state;
  end

  // Half period counter restarts on each taken word so beats stay aligned
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt <= '0;
    else
      cnt <= (load || tick) ? '0 : cnt + 4'h1;
  end

  // Beat index and strobe phase; four falls per burst leave the phase as it began
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      beat <= '0;
      strobe_phase <= 1'b0;
    end
    else
    begin
      if (load && open_now)
        beat <= '0;
      else if (load)
        beat <= beat + BEAT_W'(1);
      if (fall)
        strobe_phase <= ~strobe_phase;
    end
  end

  // ****************************************
  // Line flops
  // ****************************************
  // Data and inversion lines change only when a word is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wire_data <= '1;
      inv_n <= '1;
    end
    else if (load)
    begin
      wire_data <= next_wire;
      inv_n <= next_inv_n;
    end
  end

  // Ready pulses one cycle after each taken word, telling the user to move on
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ready <= 1'b0;
    else
      ready <= load;
  end

  // Strobe pairs: all groups fall together, pos and neg in turn
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      spos_n <= '1;
      sneg_n <= '1;
    end
    else if (fall)
    begin
      spos_n <= {GROUPS{strobe_phase}};
      sneg_n <= {GROUPS{~strobe_phase}};
    end
  end

  // Valid and busy follow the next state so they line up with the data lines
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      valid_n <= 1'b1;
      busy_n <= 1'b1;
    end
    else
    begin
      valid_n <= ~beat_next;
      busy_n <= (next_state == FQ_IDLE);
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Every pin and send_ready come straight from a flop
  assign send_ready = ready;
  assign bus.data_n = wire_data;
  assign bus.group_invert_n = inv_n;
  assign bus.data_strobe_pos_n = spos_n;
  assign bus.data_strobe_neg_n = sneg_n;
  assign bus.data_valid_n = valid_n;
  assign bus.data_bus_in_use_n = busy_n;
endmodule // fqdbi_driver

//--- fqdbi_receiver.sv
// Receiving end: samples strobes, latches data on each strobe fall.
// Assumes the strobes toggle alternately, slow against clk.
`timescale 1ns/10ps
module fqdbi_receiver
  import fqdbi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  fqdbi_if.receiver bus,
  output logic [DATA_W-1:0] recv_word,
  output logic recv_valid,
  output logic bus_in_use
);
  // ****************************************
  // Synchronisers
  // ****************************************
  // Two flops on every bus line; lines are settled by strobe fall
  logic [DATA_W+3*GROUPS+1:0] s1;
  logic [DATA_W+3*GROUPS+1:0] s2;
  logic [2*GROUPS-1:0] st_prev;
  wire [DATA_W+3*GROUPS+1:0] raw = {bus.data_n, bus.group_invert_n, bus.data_strobe_pos_n,
    bus.data_strobe_neg_n, bus.data_valid_n, bus.data_bus_in_use_n};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1 <= '1;
      s2 <= '1;
      st_prev <= '1;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
      st_prev <= s2[2*GROUPS+1:2];
    end
  end

  wire [DATA_W-1:0] d_n = s2[DATA_W+3*GROUPS+1:3*GROUPS+2];
  wire [GROUPS-1:0] inv_n = s2[3*GROUPS+1:2*GROUPS+2];
  wire [2*GROUPS-1:0] st = s2[2*GROUPS+1:2];
  wire v_n = s2[1];
  wire b_n = s2[0];
  // Falling edge of either strobe in each group
  wire [2*GROUPS-1:0] fell = st_prev & ~st;
  logic [DATA_W-1:0] word;

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++)
    begin : g_dec
      wire [GROUP_W-1:0] lv = d_n[g*GROUP_W +: GROUP_W];
      // Undo inversion, then active-low encoding
      assign word[g*GROUP_W +: GROUP_W] = inv_n[g] ? ~lv : lv;
    end
  endgenerate

  wire got = (|fell) & ~v_n;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      recv_word <= '0;
      recv_valid <= 1'b0;
      bus_in_use <= 1'b0;
    end
    else
    begin
      recv_valid <= got;
      if (got)
        recv_word <= word;
      bus_in_use <= ~b_n;
    end
  end
endmodule // fqdbi_receiver

//--- fqdbi_properties.sv
// Checker for the shared data phase lines.
// Assumes the bench places it beside the interface.
`timescale 1ns/10ps
module fqdbi_properties
  import fqdbi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [DATA_W-1:0] data_n,
  input wire logic [GROUPS-1:0] data_strobe_pos_n,
  input wire logic [GROUPS-1:0] data_strobe_neg_n,
  input wire logic [GROUPS-1:0] group_invert_n,
  input wire logic data_valid_n,
  input wire logic data_bus_in_use_n
);
  // ****************************************
  // Line properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Count groups flipping more than half their lines
  function automatic int over_half(logic [DATA_W-1:0] a, logic [DATA_W-1:0] b);
    int n;
    n = 0;
    for (int g = 0; g < GROUPS; g++)
      n += int'($countones(a[g*GROUP_W +: GROUP_W] ^ b[g*GROUP_W +: GROUP_W]) > GROUP_W / 2);
    return n;
  endfunction
  property p_busy; !data_valid_n |-> !data_bus_in_use_n; endproperty
  a_busy: assert property (p_busy) else $error("valid without busy");
  property p_pair; (&data_strobe_pos_n || ~|data_strobe_pos_n); endproperty
  a_pair: assert property (p_pair) else $error("strobe groups split");
  property p_fall; ($fell(data_strobe_pos_n[0]) || $fell(data_strobe_neg_n[0])) |-> !data_valid_n;
  endproperty
  a_fall: assert property (p_fall) else $error("strobe fall outside valid");
  property p_alt; !($fell(data_strobe_pos_n[0]) && $fell(data_strobe_neg_n[0])); endproperty
  a_alt: assert property (p_alt) else $error("both strobes fell");
  property p_flips; !data_valid_n |-> over_half(data_n, $past(data_n)) == 0; endproperty
  a_flips: assert property (p_flips) else $error("group flipped over half");
  property p_hold; $changed(data_n) |=> $stable(data_n)[*3]; endproperty
  a_hold: assert property (p_hold) else $error("data beat too short");
  property p_inv; $changed(group_invert_n) |=> $stable(group_invert_n)[*3]; endproperty
  a_inv: assert property (p_inv) else $error("inversion beat too short");
  property p_len; $fell(data_valid_n) |-> !data_valid_n[*8] ##1 !data_valid_n[*8]; endproperty
  a_len: assert property (p_len) else $error("burst under four beats");
  property p_first; $fell(data_valid_n) |-> ##[1:3] $fell(data_strobe_pos_n[0]); endproperty
  a_first: assert property (p_first) else $error("first strobe late");
endmodule // fqdbi_properties

//--- fqdbi_tb.sv
// Bench joining both ends over the interface with random bursts.
// Assumes the designer's package, interface and both ends.
`timescale 1ns/10ps
module fqdbi_tb
  import fqdbi_pkg::*;
;
  logic clk, rst, send_valid, send_ready, recv_valid, bus_in_use;
  logic [DATA_W-1:0] send_word, recv_word, dec;
  logic [DATA_W-1:0] exp_q[$], wire_q[$];
  logic [GROUPS-1:0] pos_d, neg_d;
  int n_fail, compares, cyc, gap;
  bit [31:0] seed;
  fqdbi_if bus();
  fqdbi_driver u_fqdbi_driver (.clk(clk), .rst(rst), .send_word(send_word),
    .send_valid(send_valid), .send_ready(send_ready), .bus(bus));
  fqdbi_receiver u_fqdbi_receiver (.clk(clk), .rst(rst), .bus(bus), .recv_word(recv_word),
    .recv_valid(recv_valid), .bus_in_use(bus_in_use));
  fqdbi_properties u_fqdbi_properties (.clk(clk), .rst(rst), .data_n(bus.data_n),
    .data_strobe_pos_n(bus.data_strobe_pos_n), .data_strobe_neg_n(bus.data_strobe_neg_n),
    .group_invert_n(bus.group_invert_n), .data_valid_n(bus.data_valid_n),
    .data_bus_in_use_n(bus.data_bus_in_use_n));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic bit [31:0] xs(bit [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Decode the wire itself at each strobe fall
  always @(negedge clk)
  begin
    pos_d <= bus.data_strobe_pos_n;
    neg_d <= bus.data_strobe_neg_n;
    if (!rst && ((pos_d[0] && !bus.data_strobe_pos_n[0]) || (neg_d[0] && !bus.data_strobe_neg_n[0])))
    begin
      for (int g = 0; g < GROUPS; g++)
        dec[g*GROUP_W +: GROUP_W] = bus.group_invert_n[g] ? ~bus.data_n[g*GROUP_W +: GROUP_W]
          : bus.data_n[g*GROUP_W +: GROUP_W];
      check(dec, wire_q.size() ? wire_q.pop_front() : ~dec);
    end
  end
  // Oldest note against each received word
  always @(negedge clk)
    if (recv_valid === 1'b1)
    begin
      check(recv_word, exp_q.size() ? exp_q.pop_front() : ~recv_word);
      check({63'h0, bus_in_use}, 64'h1);
    end
  // Bursts: complements toggle inversion, repeats leave lines still, gaps idle the bus
  initial
  begin
    rst = 1'b1;
    seed = 32'hD8940B8C;
    send_word = {seed, xs(seed)};
    send_valid = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check({63'h0, bus.data_bus_in_use_n}, 64'h1);
    send_valid = 1'b1;
    for (int n = 0; n < 160 && cyc < 20000; cyc++)
    begin
      @(negedge clk);
      if (send_ready === 1'b1)
      begin
        exp_q.push_back(send_word);
        wire_q.push_back(send_word);
        n++;
        seed = xs(seed);
        send_word <= seed[0] ? ~send_word : (seed[1] ? send_word : {seed, xs(seed)});
        gap = (n % 4 == 0 && (seed[2] || n == 160)) ? 20 : 0;
        send_valid <= (gap == 0);
      end
      else if (gap > 0)
        gap--;
      else
        send_valid <= 1'b1;
    end
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge clk);
    repeat (8) @(negedge clk);
    check({63'h0, bus_in_use}, 64'h0);
    check({63'h0, bus.data_valid_n}, 64'h1);
    if (cyc >= 20000 || exp_q.size() > 0 || wire_q.size() > 0)
      n_fail++;
    report_and_stop();
  end
endmodule // fqdbi_tb
